// File: verif/dac_offset_gain_calibration_tb.sv
// Testbench: APB-driven host end joined to the device end over the link
`timescale 1ns/10ps
module dac_offset_gain_calibration_tb;
  import doc_pkg::*;
  logic        clk_in, arst_n_in, psel, penable, pwrite, pready, pslverr, load_out;
  logic [7:0]  paddr, adc_code_in;
  logic [31:0] pwdata, prdata, loop_na_out, rd;
  logic [1:0]  range_sel_in;
  logic [15:0] out_code_out;
  logic        er;
  int          error_cnt, check_count;
  int          load_cnt = 0;
  doc_link_if link_if();
  doc_host doc_host_inst(.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link_if));
  doc_device doc_device_inst(.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
    .link(link_if), .adc_code_in(adc_code_in), .range_sel_in(range_sel_in),
    .out_code_out(out_code_out), .loop_na_out(loop_na_out), .load_out(load_out));
  doc_link_props doc_link_props_inst(.clk_in(clk_in), .arst_n_in(arst_n_in),
    .lk_req(link_if.lk_req), .lk_wr(link_if.lk_wr), .lk_addr(link_if.lk_addr),
    .lk_wdata(link_if.lk_wdata), .lk_ack(link_if.lk_ack), .lk_rdata(link_if.lk_rdata));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // Counts apply pulses so the first data write is seen to load exactly once
  always @(posedge clk_in) begin
    if (load_out === 1'b1) begin
      load_cnt <= load_cnt + 1;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Status is polled so the bench never assumes the link latency
  task automatic lk(input logic w, input logic [1:0] a, input logic [15:0] d);
    int n;
    n = 0;
    apb(1'b1, DOC_APB_CMD, {13'h0, w, a, d});
    do begin
      apb(1'b0, DOC_APB_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    if (n >= 40) error_cnt++;
    if (w == 1'b0) apb(1'b0, DOC_APB_RDATA, 32'h0);
  endtask
  function automatic logic [15:0] corr(input logic [15:0] d, g, o);
    longint v;
    v = ((longint'(d) * longint'(g)) >> 16) + longint'(o) - 32768;
    corr = (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : 16'(v);
  endfunction
  logic [15:0] tv [2][3] = '{'{16'h0000, 16'hffff, 16'h0000}, '{16'hffff, 16'hffff, 16'hffff}};
  logic [31:0] zs [3] = '{DOC_ZERO_4_20, DOC_ZERO_38_21, DOC_ZERO_32_24};
  logic [31:0] sp [3] = '{DOC_SPAN_4_20, DOC_SPAN_38_21, DOC_SPAN_32_24};
  logic [7:0]  ac [3] = '{8'h00, 8'hff, 8'h5a};
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    final_report();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    adc_code_in = 8'h00;
    range_sel_in = 2'h0;
    arst_n_in = 1'b0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    lk(1'b0, DOC_ADDR_OFFSET, 16'h0);
    chk("offset reset", rd, 32'h8000);
    lk(1'b0, DOC_ADDR_GAIN, 16'h0);
    chk("gain reset", rd, 32'hffff);
    chk("out reset", out_code_out, 32'h0);
    $display("test reset done");
    apb(1'b1, DOC_APB_CTRL, 32'h0);
    lk(1'b1, DOC_ADDR_DATA, 16'h1000);
    chk("out data", out_code_out, corr(16'h1000, 16'hffff, 16'h8000));
    chk("load pulses", load_cnt, 32'h1);
    lk(1'b1, DOC_ADDR_OFFSET, 16'h8100);
    chk("out after offset", out_code_out, corr(16'h1000, 16'hffff, 16'h8000));
    lk(1'b1, DOC_ADDR_GAIN, 16'h8000);
    chk("out after gain", out_code_out, corr(16'h1000, 16'hffff, 16'h8000));
    lk(1'b0, DOC_ADDR_OFFSET, 16'h0);
    chk("offset readback", rd, 32'h8100);
    lk(1'b0, DOC_ADDR_GAIN, 16'h0);
    chk("gain readback", rd, 32'h8000);
    lk(1'b1, DOC_ADDR_DATA, 16'h2000);
    chk("out applied", out_code_out, corr(16'h2000, 16'h8000, 16'h8100));
    $display("test deferred apply done");
    apb(1'b1, DOC_APB_CTRL, 32'h1);
    foreach (tv[i]) begin
      lk(1'b1, DOC_ADDR_DATA, tv[i][0]);
      lk(1'b1, DOC_ADDR_GAIN, tv[i][1]);
      lk(1'b1, DOC_ADDR_OFFSET, tv[i][2]);
      chk("out clamp", out_code_out, corr(tv[i][0], tv[i][1], tv[i][2]));
    end
    for (int r = 0; r < 3; r++) begin
      range_sel_in <= 2'(r);
      repeat (6) @(posedge clk_in);
      chk("loop current", loop_na_out, zs[r] + 32'((64'(sp[r]) * 64'hffff) >> 16));
    end
    $display("test clamp and range done");
    foreach (ac[i]) begin
      adc_code_in <= ac[i];
      repeat (4) @(posedge clk_in);
      lk(1'b0, DOC_ADDR_FAULT, 16'h0);
      chk("adc code", rd, {24'h0, ac[i]});
      apb(1'b0, DOC_APB_VOLT, 32'h0);
      chk("volt mv", rd, (int'(ac[i]) * 2500) >> 8);
      apb(1'b0, DOC_APB_TEMP, 32'h0);
      chk("temp mc", rd, 312000 - 1559 * int'(ac[i]));
    end
    $display("test adc done");
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", er, 32'h1);
    $display("test unmapped done");
    final_report();
  end
endmodule

// File: verif/doc_link_props.sv
// Link checker between the calibration host and device ends
`timescale 1ns/10ps
module doc_link_props
  import doc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        lk_req,
  input  wire logic        lk_wr,
  input  wire logic [1:0]  lk_addr,
  input  wire logic [15:0] lk_wdata,
  input  wire logic        lk_ack,
  input  wire logic [15:0] lk_rdata
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_ack_next; lk_req && !lk_ack |=> lk_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after req");
  property p_ack_cause; lk_ack |-> $past(lk_req) && !$past(lk_ack); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_pulse; lk_ack |=> !lk_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_req_hold;
    lk_req && !lk_ack |=> lk_req && $stable(lk_wr) && $stable(lk_addr) && $stable(lk_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_rdata_hold; !lk_ack |-> $stable(lk_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved without ack");
  property p_fault_hi;
    lk_ack && !$past(lk_wr) && $past(lk_addr) == DOC_ADDR_FAULT |-> lk_rdata[15:8] == 8'h00;
  endproperty
  a_fault_hi: assert property (p_fault_hi) else $error("fault readback upper byte set");
  property p_rose_seq; $rose(lk_req) |-> ##1 lk_ack ##1 !lk_ack; endproperty
  a_rose_seq: assert property (p_rose_seq) else $error("transfer walk broken");
  property p_wr_keep; lk_ack && $past(lk_wr) |-> $stable(lk_rdata); endproperty
  a_wr_keep: assert property (p_wr_keep) else $error("write disturbed readback");
  c_off: cover property (lk_ack && lk_wr && lk_addr == DOC_ADDR_OFFSET);
  c_gain: cover property (lk_ack && lk_wr && lk_addr == DOC_ADDR_GAIN);
  c_fault: cover property (lk_ack && !lk_wr && lk_addr == DOC_ADDR_FAULT);
endmodule

// File: verilog/doc_device.sv
// DAC end: offset/gain registers, atomic apply, ADC readback
`timescale 1ns/10ps
module doc_device
  import doc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  doc_link_if.dev          link,
  input  wire logic [7:0]  adc_code_in,
  input  wire logic [1:0]  range_sel_in,
  output logic      [15:0] out_code_out,
  output logic      [31:0] loop_na_out,
  output logic             load_out
);

  typedef struct packed {
    logic [7:0]  adc_s1;
    logic [7:0]  adc_s2;
    logic [1:0]  rng_s1;
    logic [1:0]  rng_s2;
    logic [15:0] off_pend;
    logic [15:0] gain_pend;
    logic [15:0] data;
    logic [15:0] off_app;
    logic [15:0] gain_app;
    logic [15:0] out_code;
    logic [31:0] loop_na;
    logic        ack;
    logic [15:0] rdata;
    logic        load;
  } doc_dev_state_t;

  localparam doc_dev_state_t DOC_DEV_RST = '{
    adc_s1:    8'h00,
    adc_s2:    8'h00,
    rng_s1:    2'h0,
    rng_s2:    2'h0,
    off_pend:  DOC_OFFSET_RST,
    gain_pend: DOC_GAIN_RST,
    data:      DOC_DATA_RST,
    off_app:   DOC_OFFSET_RST,
    gain_app:  DOC_GAIN_RST,
    out_code:  16'h0000,
    loop_na:   DOC_ZERO_4_20,
    ack:       1'b0,
    rdata:     16'h0000,
    load:      1'b0
  };

  doc_dev_state_t st_r;
  doc_dev_state_t st_nxt;

  // Corrected code from a data word and a gain/offset pair
  function automatic logic [15:0] doc_correct(input logic [15:0] d,
                                              input logic [15:0] g,
                                              input logic [15:0] o);
    logic [31:0] prod;
    logic [17:0] sum;
    prod = d * g;
    // Offset is biased by half scale
    sum  = {2'b00, prod[31:16]} + {2'b00, o};
    if (sum < DOC_OFFSET_ZERO) begin
      // Zero scale is a floor, never lowered
      doc_correct = 16'h0000;
    end else if ((sum - DOC_OFFSET_ZERO) > DOC_CODE_MAX) begin
      doc_correct = 16'hffff;
    end else begin
      doc_correct = 16'(sum - DOC_OFFSET_ZERO);
    end
  endfunction

  // Range decoding, used for zero scale and for span
  function automatic logic [31:0] doc_range_zero(input logic [1:0] r);
    unique case (r)
      DOC_RANGE_38_21: doc_range_zero = DOC_ZERO_38_21;
      DOC_RANGE_32_24: doc_range_zero = DOC_ZERO_32_24;
      default:         doc_range_zero = DOC_ZERO_4_20;
    endcase
  endfunction

  function automatic logic [31:0] doc_range_span(input logic [1:0] r);
    unique case (r)
      DOC_RANGE_38_21: doc_range_span = DOC_SPAN_38_21;
      DOC_RANGE_32_24: doc_range_span = DOC_SPAN_32_24;
      default:         doc_range_span = DOC_SPAN_4_20;
    endcase
  endfunction

  logic        take;
  logic [47:0] scaled;

  always_comb begin
    st_nxt = st_r;
    take   = link.lk_req && !st_r.ack;
    scaled = 48'h0;
    if (ce_in) begin
      // Pins from outside the clock domain: two flops before use
      st_nxt.adc_s1 = adc_code_in;
      st_nxt.adc_s2 = st_r.adc_s1;
      st_nxt.rng_s1 = range_sel_in;
      st_nxt.rng_s2 = st_r.rng_s1;
      st_nxt.ack    = take;
      st_nxt.load   = 1'b0;
      if (take && link.lk_wr) begin
        unique case (link.lk_addr)
          DOC_ADDR_OFFSET: begin
            // Held pending; output untouched until data write
            st_nxt.off_pend = link.lk_wdata;
          end
          DOC_ADDR_GAIN: begin
            st_nxt.gain_pend = link.lk_wdata;
          end
          DOC_ADDR_DATA: begin
            // Data, gain and offset move together in one edge
            st_nxt.data     = link.lk_wdata;
            st_nxt.off_app  = st_r.off_pend;
            st_nxt.gain_app = st_r.gain_pend;
            st_nxt.out_code = doc_correct(link.lk_wdata, st_r.gain_pend,
                                          st_r.off_pend);
            st_nxt.load     = 1'b1;
          end
          DOC_ADDR_FAULT: begin
            // Fault register is read-only here; writes are dropped
          end
        endcase
      end
      if (take && !link.lk_wr) begin
        unique case (link.lk_addr)
          DOC_ADDR_DATA:   st_nxt.rdata = st_r.data;
          DOC_ADDR_OFFSET: st_nxt.rdata = st_r.off_pend;
          DOC_ADDR_GAIN:   st_nxt.rdata = st_r.gain_pend;
          DOC_ADDR_FAULT:  st_nxt.rdata = {8'h00, st_r.adc_s2};
        endcase
      end
      // Range span scaled by the applied code, added to zero scale
      scaled = 48'(doc_range_span(st_r.rng_s2)) * 48'(st_r.out_code);
      st_nxt.loop_na = doc_range_zero(st_r.rng_s2) + scaled[47:16];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= DOC_DEV_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.lk_ack   = st_r.ack;
  assign link.lk_rdata = st_r.rdata;
  assign out_code_out  = st_r.out_code;
  assign loop_na_out   = st_r.loop_na;
  assign load_out      = st_r.load;

endmodule

// File: verilog/doc_host.sv
// Host end: APB command registers driving the device link
`timescale 1ns/10ps
module doc_host
  import doc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  doc_link_if.host         link
);

  typedef enum logic [1:0] {H_IDLE, H_REQ, H_APPLY} doc_hstate_t;

  typedef struct packed {
    doc_hstate_t fsm;
    logic        wr;
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic [15:0] shadow;
    logic [15:0] rdata;
    logic [31:0] volt_mv;
    logic [31:0] temp_mc;
    logic        auto_apply;
  } doc_host_state_t;

  localparam doc_host_state_t DOC_HOST_RST = '{
    fsm:        H_IDLE,
    wr:         1'b0,
    addr:       2'h0,
    wdata:      16'h0000,
    shadow:     DOC_DATA_RST,
    rdata:      16'h0000,
    volt_mv:    32'h0,
    temp_mc:    DOC_TEMP_MC_ZERO,
    auto_apply: DOC_AUTO_APPLY_RST
  };

  doc_host_state_t st_r;
  doc_host_state_t st_nxt;
  logic            acc;
  logic            mapped;
  logic            busy;

  always_comb begin
    busy    = (st_r.fsm != H_IDLE);
    acc     = psel && penable;
    mapped  = paddr inside {DOC_APB_CMD, DOC_APB_STATUS, DOC_APB_RDATA,
                            DOC_APB_VOLT, DOC_APB_TEMP, DOC_APB_CTRL};
    pready  = 1'b1;
    // Unmapped address, or a command while one is in flight
    pslverr = acc && (!mapped || (pwrite && paddr == DOC_APB_CMD && busy));
    unique case (paddr)
      DOC_APB_STATUS: prdata = {31'h0, busy};
      DOC_APB_RDATA:  prdata = {16'h0, st_r.rdata};
      DOC_APB_VOLT:   prdata = st_r.volt_mv;
      DOC_APB_TEMP:   prdata = st_r.temp_mc;
      DOC_APB_CTRL:   prdata = {31'h0, st_r.auto_apply};
      default:        prdata = 32'h0;
    endcase
    st_nxt = st_r;
    if (ce_in) begin
      if (acc && pwrite && paddr == DOC_APB_CTRL) begin
        st_nxt.auto_apply = pwdata[0];
      end
      unique case (st_r.fsm)
        H_IDLE: begin
          if (acc && pwrite && paddr == DOC_APB_CMD) begin
            st_nxt.wr    = pwdata[DOC_CMD_WR_BIT];
            st_nxt.addr  = pwdata[DOC_CMD_ADDR_LSB +: 2];
            st_nxt.wdata = pwdata[15:0];
            st_nxt.fsm   = H_REQ;
          end
        end
        H_REQ, H_APPLY: begin
          if (link.lk_ack) begin
            st_nxt.fsm = H_IDLE;
            if (st_r.wr && st_r.addr == DOC_ADDR_DATA) begin
              st_nxt.shadow = st_r.wdata;
            end
            // Gain/offset need a data write to act
            if (st_r.fsm == H_REQ && st_r.wr && st_r.auto_apply &&
                (st_r.addr == DOC_ADDR_OFFSET || st_r.addr == DOC_ADDR_GAIN)) begin
              st_nxt.fsm   = H_APPLY;
              st_nxt.addr  = DOC_ADDR_DATA;
              st_nxt.wdata = st_r.shadow;
            end
            if (!st_r.wr) begin
              st_nxt.rdata = link.lk_rdata;
            end
            if (!st_r.wr && st_r.addr == DOC_ADDR_FAULT) begin
              st_nxt.volt_mv = (32'(link.lk_rdata[7:0]) * DOC_VOLT_MV_FS) >> 8;
              st_nxt.temp_mc = DOC_TEMP_MC_ZERO -
                               32'(link.lk_rdata[7:0]) * DOC_TEMP_MC_STEP;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= DOC_HOST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.lk_req   = (st_r.fsm != H_IDLE);
  assign link.lk_wr    = st_r.wr;
  assign link.lk_addr  = st_r.addr;
  assign link.lk_wdata = st_r.wdata;

endmodule

// File: verilog/doc_link_if.sv
// Register link between the calibration host and the DAC device
`timescale 1ns/10ps
interface doc_link_if;
  logic        lk_req;
  logic        lk_wr;
  logic [1:0]  lk_addr;
  logic [15:0] lk_wdata;
  logic        lk_ack;
  logic [15:0] lk_rdata;

  modport dev  (input lk_req, input lk_wr, input lk_addr, input lk_wdata,
                output lk_ack, output lk_rdata);
  modport host (output lk_req, output lk_wr, output lk_addr, output lk_wdata,
                input lk_ack, input lk_rdata);
endinterface

// File: verilog/doc_pkg.sv
// Shared constants of the DAC offset/gain calibration ends
package doc_pkg;

  // Device register addresses on the link
  localparam logic [1:0]  DOC_ADDR_DATA     = 2'h0;
  localparam logic [1:0]  DOC_ADDR_OFFSET   = 2'h1;
  localparam logic [1:0]  DOC_ADDR_GAIN     = 2'h2;
  localparam logic [1:0]  DOC_ADDR_FAULT    = 2'h3;

  // Reset values
  localparam logic [15:0] DOC_DATA_RST      = 16'h0000;
  localparam logic [15:0] DOC_OFFSET_RST    = 16'h8000;
  localparam logic [15:0] DOC_GAIN_RST      = 16'hffff;
  localparam logic [17:0] DOC_OFFSET_ZERO   = 18'h08000;
  localparam logic [17:0] DOC_CODE_MAX      = 18'h0ffff;

  // Current ranges: zero-scale and span in nA
  localparam logic [1:0]  DOC_RANGE_4_20    = 2'h0;
  localparam logic [1:0]  DOC_RANGE_38_21   = 2'h1;
  localparam logic [1:0]  DOC_RANGE_32_24   = 2'h2;
  localparam logic [31:0] DOC_ZERO_4_20     = 32'h003d_0900;
  localparam logic [31:0] DOC_SPAN_4_20     = 32'h00f4_2400;
  localparam logic [31:0] DOC_ZERO_38_21    = 32'h0039_fbc0;
  localparam logic [31:0] DOC_SPAN_38_21    = 32'h0106_7380;
  localparam logic [31:0] DOC_ZERO_32_24    = 32'h0030_d400;
  localparam logic [31:0] DOC_SPAN_32_24    = 32'h013d_6200;

  // ADC conversion factors on the host side
  localparam logic [31:0] DOC_VOLT_MV_FS    = 32'h0000_09c4;
  localparam logic [31:0] DOC_TEMP_MC_ZERO  = 32'h0004_c2c0;
  localparam logic [31:0] DOC_TEMP_MC_STEP  = 32'h0000_0617;

  // Host APB register byte offsets
  localparam logic [7:0]  DOC_APB_CMD       = 8'h00;
  localparam logic [7:0]  DOC_APB_STATUS    = 8'h04;
  localparam logic [7:0]  DOC_APB_RDATA     = 8'h08;
  localparam logic [7:0]  DOC_APB_VOLT      = 8'h0c;
  localparam logic [7:0]  DOC_APB_TEMP      = 8'h10;
  localparam logic [7:0]  DOC_APB_CTRL      = 8'h14;

  // CMD field positions
  localparam int          DOC_CMD_ADDR_LSB  = 16;
  localparam int          DOC_CMD_WR_BIT    = 18;
  localparam logic        DOC_AUTO_APPLY_RST = 1'b1;

endpackage
